/* odt_pkg.sv */
// Purpose: Shared constants and types for the termination control block.
// Assumes: One aligned 32-bit word per register on the APB bus.
// Notes: Latencies are counted in edges of the sampled memory clock.
package odt_pkg;

    // ======================================================================
    // Register map
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;

    // ======================================================================
    // Configuration fields
    localparam int CFG_DLL_PD_BIT = 0;
    localparam int CFG_NOM_LSB = 1;
    localparam int CFG_TDQS_BIT = 4;
    localparam int CFG_WR_LSB = 5;
    localparam int CFG_BMODE_LSB = 8;
    localparam int CFG_CWL_LSB = 12;
    localparam int CFG_AL_LSB = 16;
    localparam logic [31:0] CFG_RESET = 32'h0000_5000;

    // ======================================================================
    // Status fields
    localparam int ST_TERM_BIT = 0;
    localparam int ST_WRSEL_BIT = 1;
    localparam int ST_PD_BIT = 2;
    localparam int ST_SR_BIT = 3;
    localparam int ST_SYNC_BIT = 4;
    localparam int ST_EN_BIT = 5;
    localparam int ST_LAT_LSB = 8;

    // ======================================================================
    // Timing counts in memory clock cycles
    localparam logic [5:0] LAT_OFFSET = 6'h02;
    localparam logic [5:0] CWN4_EXTRA = 6'h04;
    localparam logic [5:0] CWN8_EXTRA = 6'h06;
    localparam int ODTH_SHORT = 4;
    localparam int ODTH_LONG = 6;
    localparam int HIST_W = 40;
    localparam logic [5:0] LAT_MAX = 6'h21;

    typedef enum logic [1:0] {
        BM_BL8 = 2'h0,
        BM_BC4 = 2'h1,
        BM_OTF = 2'h2
    } burst_mode_t;

    typedef enum logic [2:0] {
        PS_ACTIVE = 3'b001,
        PS_PDOWN = 3'b010,
        PS_SREF = 3'b100
    } pwr_state_t;

endpackage

/* link_sample_if.sv */
// Purpose: Carries memory pin samples taken at each rising memory clock.
// Assumes: Driven by the pin sampler, read by the control block.
// Notes: All fields are valid in the cycle where ck_rise is high.
interface link_sample_if;
    logic ck_rise;
    logic cke;
    logic odt;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic a12;

    modport src (output ck_rise, cke, odt, cs_n, ras_n, cas_n, we_n, a12);
    modport snk (input ck_rise, cke, odt, cs_n, ras_n, cas_n, we_n, a12);
endinterface

/* ck_pin_sampler.sv */
// Purpose: Synchronises memory pins and finds rising memory clock edges.
// Assumes: The memory clock is several times slower than pclk.
// Notes: Pins must be stable for three pclk cycles around each edge.
module ck_pin_sampler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ck,
    input wire logic [7:0] pins,
    link_sample_if.src ls
);
    // ======================================================================
    // Two flops on every pin; outputs read the second stage, and ck gets a third flop for edge detection.
    logic [8:0] meta_r;
    logic [8:0] sync_r;
    logic ck_last_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 9'h000;
            sync_r <= 9'h000;
            ck_last_r <= 1'b0;
        end else begin
            meta_r <= {ck, pins};
            sync_r <= meta_r;
            ck_last_r <= sync_r[8];
        end
    end

    always_comb begin
        ls.ck_rise = sync_r[8] & ~ck_last_r;
        ls.cke = sync_r[0];
        ls.odt = sync_r[1];
        ls.cs_n = sync_r[2];
        ls.ras_n = sync_r[3];
        ls.cas_n = sync_r[4];
        ls.we_n = sync_r[5];
        ls.a12 = sync_r[6];
    end
endmodule

/* odt_pd_ctrl.sv */
// Purpose: Power-down exit and on-die termination control of the memory.
// Assumes: APB master on pclk; memory pins sampled through ck_pin_sampler.
// Notes: Asynchronous termination timing is not modelled.
module odt_pd_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ck,
    input wire logic cke,
    input wire logic odt,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic a12,
    output logic term_dq_on,
    output logic term_tdqs_on,
    output logic term_wr_sel,
    output logic [2:0] term_strength,
    output logic in_power_down,
    output logic in_self_refresh
);
    // ======================================================================
    // Pin sampling
    link_sample_if ls ();

    ck_pin_sampler u_sampler (
        .pclk(pclk),
        .presetn(presetn),
        .ck(ck),
        .pins({1'b0, a12, we_n, cas_n, ras_n, cs_n, odt, cke}),
        .ls(ls)
    );

    // ======================================================================
    // Helpers
    localparam logic [5:0] LAT_LIM = odt_pkg::LAT_OFFSET;
    localparam int HW = odt_pkg::HIST_W;

    function automatic logic is_nop(input logic c, r, a, w);
        return c | (r & a & w);
    endfunction

    function automatic logic is_write(input logic c, r, a, w);
        return !c & r & !a & !w;
    endfunction

    function automatic logic is_refresh(input logic c, r, a, w);
        return !c & !r & !a & w;
    endfunction

    function automatic logic [5:0] calc_lat(input logic [3:0] write_cas_latency,
                                            input logic [4:0] al);
        logic [5:0] sum;
        sum = 6'(write_cas_latency) + 6'(al);
        if (sum < LAT_LIM) return 6'h00;
        sum = sum - odt_pkg::LAT_OFFSET;
        return (sum > odt_pkg::LAT_MAX) ? odt_pkg::LAT_MAX : sum;
    endfunction

    // ======================================================================
    // Configuration register
    logic [31:0] cfg_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] status;
    logic wr_access;
    logic addr_ok;

    logic dll_pd_keep;
    logic [2:0] rtt_nom;
    logic tdqs_en;
    logic [1:0] rtt_wr;
    logic [1:0] bmode;
    logic [5:0] lat;
    logic odt_en;
    logic dyn_en;

    assign dll_pd_keep = cfg_r[odt_pkg::CFG_DLL_PD_BIT];
    assign rtt_nom = cfg_r[odt_pkg::CFG_NOM_LSB +: 3];
    assign tdqs_en = cfg_r[odt_pkg::CFG_TDQS_BIT];
    assign rtt_wr = cfg_r[odt_pkg::CFG_WR_LSB +: 2];
    assign bmode = cfg_r[odt_pkg::CFG_BMODE_LSB +: 2];
    assign lat = calc_lat(cfg_r[odt_pkg::CFG_CWL_LSB +: 4],
                          cfg_r[odt_pkg::CFG_AL_LSB +: 5]);
    assign odt_en = (rtt_nom != 3'h0) || (rtt_wr != 2'h0);
    assign dyn_en = (rtt_wr != 2'h0);

    assign addr_ok = (paddr == odt_pkg::CFG_OFS) ||
                     (paddr == odt_pkg::STAT_OFS);
    assign wr_access = psel & penable & pready_r & pwrite &
                       (paddr == odt_pkg::CFG_OFS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= odt_pkg::CFG_RESET;
        end else if (wr_access) begin
            cfg_r <= pwdata;
        end
    end

    // One wait-free access: pready is raised in the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= psel & ~penable;
            pslverr_r <= psel & ~penable & ~addr_ok;
            if (psel & ~penable & ~pwrite) begin
                if (paddr == odt_pkg::CFG_OFS) prdata_r <= cfg_r;
                else if (paddr == odt_pkg::STAT_OFS) prdata_r <= status;
                else prdata_r <= 32'h0000_0000;
            end
        end
    end

    // ======================================================================
    // Power state tracking
    odt_pkg::pwr_state_t state_r;
    logic nop_cmd;

    assign nop_cmd = is_nop(ls.cs_n, ls.ras_n, ls.cas_n, ls.we_n);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= odt_pkg::PS_ACTIVE;
        end else if (ls.ck_rise) begin
            unique case (state_r)
                odt_pkg::PS_ACTIVE: begin
                    if (!ls.cke && is_refresh(ls.cs_n, ls.ras_n,
                                              ls.cas_n, ls.we_n)) begin
                        state_r <= odt_pkg::PS_SREF;
                    end else if (!ls.cke && nop_cmd) begin
                        state_r <= odt_pkg::PS_PDOWN;
                    end
                end
                odt_pkg::PS_PDOWN: begin
                    if (ls.cke && nop_cmd) begin
                        state_r <= odt_pkg::PS_ACTIVE;
                    end
                end
                odt_pkg::PS_SREF: begin
                    if (ls.cke && nop_cmd) state_r <= odt_pkg::PS_ACTIVE;
                end
                default: state_r <= odt_pkg::PS_ACTIVE;
            endcase
        end
    end

    // Synchronous timing holds unless the DLL is frozen in power-down.
    logic sync_mode;
    assign sync_mode = !(state_r == odt_pkg::PS_PDOWN && !dll_pd_keep);

    // ======================================================================
    // ODT and write history, one bit per memory clock edge
    logic [HW-1:0] odt_hist_r;
    logic [HW-1:0] wr_hist_r;
    logic [HW-1:0] bl8_hist_r;
    logic odt_in;
    logic wr_cmd;
    logic wr_bl8;

    // The pin decides on/off outside self-refresh; reads are never decoded here.
    assign odt_in = ls.odt && (state_r != odt_pkg::PS_SREF);
    assign wr_cmd = is_write(ls.cs_n, ls.ras_n, ls.cas_n, ls.we_n) &&
                    state_r == odt_pkg::PS_ACTIVE;
    assign wr_bl8 = (bmode == odt_pkg::BM_BL8) ||
                    ((bmode != odt_pkg::BM_BC4) && ls.a12);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            odt_hist_r <= '0;
            wr_hist_r <= '0;
            bl8_hist_r <= '0;
        end else if (ls.ck_rise) begin
            odt_hist_r <= {odt_hist_r[HW-2:0], odt_in};
            wr_hist_r <= {wr_hist_r[HW-2:0], wr_cmd && dyn_en};
            bl8_hist_r <= {bl8_hist_r[HW-2:0], wr_bl8};
        end
    end

    // A write selects write strength from lat edges on for four or six.
    function automatic logic in_wr_window(input logic [HW-1:0] wh,
                                          input logic [HW-1:0] bh,
                                          input logic [5:0] l);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < HW; k++) begin
            if (wh[k] && 6'(k) >= l &&
                6'(k) < l + (bh[k] ? odt_pkg::CWN8_EXTRA
                                   : odt_pkg::CWN4_EXTRA)) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // ======================================================================
    // Outputs
    logic term_on_r;
    logic term_tdqs_r;
    logic wr_sel_r;
    logic [2:0] strength_r;
    logic pd_r;
    logic sr_r;
    logic term_nxt;
    logic wr_sel_nxt;

    assign term_nxt = odt_hist_r[lat] && odt_en &&
                      state_r != odt_pkg::PS_SREF;
    assign wr_sel_nxt = dyn_en &&
        in_wr_window(wr_hist_r, bl8_hist_r, lat);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_on_r <= 1'b0;
            term_tdqs_r <= 1'b0;
            wr_sel_r <= 1'b0;
            strength_r <= 3'h0;
            pd_r <= 1'b0;
            sr_r <= 1'b0;
        end else begin
            term_on_r <= term_nxt;
            term_tdqs_r <= term_nxt && tdqs_en;
            wr_sel_r <= wr_sel_nxt;
            strength_r <= wr_sel_nxt ? {1'b0, rtt_wr} : rtt_nom;
            pd_r <= state_r == odt_pkg::PS_PDOWN;
            sr_r <= state_r == odt_pkg::PS_SREF;
        end
    end

    always_comb begin
        status = 32'h0000_0000;
        status[odt_pkg::ST_TERM_BIT] = term_on_r;
        status[odt_pkg::ST_WRSEL_BIT] = wr_sel_r;
        status[odt_pkg::ST_PD_BIT] = pd_r;
        status[odt_pkg::ST_SR_BIT] = sr_r;
        status[odt_pkg::ST_SYNC_BIT] = sync_mode;
        status[odt_pkg::ST_EN_BIT] = odt_en;
        status[odt_pkg::ST_LAT_LSB +: 6] = lat;
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign term_dq_on = term_on_r;
    assign term_tdqs_on = term_tdqs_r;
    assign term_wr_sel = wr_sel_r;
    assign term_strength = strength_r;
    assign in_power_down = pd_r;
    assign in_self_refresh = sr_r;

    // ======================================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_pd_exit;
        (state_r == odt_pkg::PS_PDOWN && ls.ck_rise && ls.cke && nop_cmd)
            |=> ##1 !pd_r;
    endproperty
    a_pd_exit: assert property (p_pd_exit)
        else $error("power-down not left on CKE high with NOP");

    property p_sref_off;
        (state_r == odt_pkg::PS_SREF) |=> !term_on_r;
    endproperty
    a_sref_off: assert property (p_sref_off)
        else $error("termination on during self-refresh");

    property p_disabled;
        !odt_en ##1 !odt_en |-> !term_on_r;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("termination on while disabled by mode bits");

    property p_tdqs;
        term_tdqs_on |-> term_dq_on && $past(tdqs_en);
    endproperty
    a_tdqs: assert property (p_tdqs)
        else $error("strobe-pair termination without enable");

    property p_turn_on;
        $rose(term_on_r) |-> $past(odt_hist_r[lat]) && $past(odt_en);
    endproperty
    a_turn_on: assert property (p_turn_on)
        else $error("termination rose without delayed ODT high");

    property p_lat;
        (cfg_r[odt_pkg::CFG_CWL_LSB +: 4] == 4'h5 &&
         cfg_r[odt_pkg::CFG_AL_LSB +: 5] == 5'h00) |-> lat == 6'h03;
    endproperty
    a_lat: assert property (p_lat)
        else $error("latency not write latency minus two");

    property p_no_dyn;
        !dyn_en ##1 !dyn_en |-> !wr_sel_r;
    endproperty
    a_no_dyn: assert property (p_no_dyn)
        else $error("write strength selected with switching disabled");

    property p_wr_ends;
        $rose(wr_sel_r) |-> ##[1:400] !wr_sel_r;
    endproperty
    a_wr_ends: assert property (p_wr_ends)
        else $error("write strength never returned to nominal");

    property p_strength;
        ##1 (!wr_sel_r && $past(rtt_nom) == rtt_nom) |->
            strength_r == rtt_nom;
    endproperty
    a_strength: assert property (p_strength)
        else $error("nominal strength not selected outside writes");

    property p_apb_ready;
        pready_r |-> $past(psel) && !$past(penable);
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("pready outside an access phase");
endmodule

/* ddr_ctrl_model.sv */
// Purpose: Memory controller model driving clock, CKE, ODT and commands.
// Assumes: The bench sequences the pins through the step task.
// Notes: The memory clock runs free, as the device needs it in power-down.
module ddr_ctrl_model #(
    parameter int EXIT_WAIT = 4
) (
    input wire logic pclk,
    output logic ck,
    output logic cke,
    output logic odt,
    output logic [3:0] cmd_n,
    output logic a12
);
    timeunit 1ns;
    timeprecision 1ns;

    // ======================================================================
    // Clock and pins
    // The phase offset keeps ck edges clear of every pclk edge.
    initial begin
        ck = 1'b0;
        cke = 1'b1;
        odt = 1'b0;
        cmd_n = 4'h7;
        a12 = 1'b0;
        #37;
        forever #200 ck = ~ck;
    end

    // Pins move one pclk after a falling edge and hold past the next one,
    // so the sampler sees them settled around each rise.
    task automatic step(input logic c, input logic o, input logic [3:0] m,
                        input logic b);
        @(negedge ck);
        @(posedge pclk);
        cke <= c;
        odt <= o;
        cmd_n <= m;
        a12 <= b;
        @(posedge pclk);
    endtask
endmodule

/* test_odt_pd_ctrl.sv */
// Purpose: Self-checking bench for power-down exit and termination control.
// Assumes: Pins are stepped once per memory clock by the controller model.
// Notes: Expected outputs come from a history of sampled pins.
module test_odt_pd_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] NOP = 4'h7;
    localparam logic [3:0] DES = 4'hf;
    localparam logic [3:0] WR = 4'h4;
    localparam logic [3:0] RD = 4'h5;
    localparam logic [3:0] REF = 4'h1;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdq, cfg_s;
    logic ck, cke, odt, a12, rde, pd_s, sref_s;
    logic [3:0] cmd_n;
    logic term_dq_on, term_tdqs_on, term_wr_sel, in_power_down;
    logic in_self_refresh;
    logic [2:0] term_strength;
    logic odt_h [64];
    int wr_h [64];
    int nk, miscompares, num_checks;
    logic [31:0] dcfg [5] = '{32'h5156, 32'h5056, 32'h5256, 32'h5336,
                              32'h46056};
    int dwat [5] = '{1, 1, 1, 0, 0};
    int dhold [5] = '{5, 7, 7, 4, 6};
    logic db [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    int enb [6] = '{1, 2, 3, 4, 5, 6};

    odt_pd_ctrl odt_pd_ctrl_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ck(ck), .cke(cke), .odt(odt),
        .cs_n(cmd_n[3]), .ras_n(cmd_n[2]), .cas_n(cmd_n[1]),
        .we_n(cmd_n[0]), .a12(a12), .term_dq_on(term_dq_on),
        .term_tdqs_on(term_tdqs_on), .term_wr_sel(term_wr_sel),
        .term_strength(term_strength), .in_power_down(in_power_down),
        .in_self_refresh(in_self_refresh));
    ddr_ctrl_model ddr_ctrl_model_inst (.pclk(pclk), .ck(ck), .cke(cke),
        .odt(odt), .cmd_n(cmd_n), .a12(a12));

    always #25 pclk = ~pclk;

    // ======================================================================
    // History of what the device sampled at each memory clock rise
    always @(posedge ck) begin
        odt_h[nk % 64] = odt && !sref_s;
        wr_h[nk % 64] = 0;
        if (cke && !pd_s && !sref_s && cmd_n == WR)
            wr_h[nk % 64] = (cfg_s[9] ? !a12 : cfg_s[8]) ? 4 : 6;
        if (sref_s || pd_s) begin
            if (cke && cmd_n[2:0] == 3'h7)
                {sref_s, pd_s} = 2'b00;
        end else if (!cke && cmd_n == REF) begin
            sref_s = 1'b1;
        end else if (!cke && cmd_n[2:0] == 3'h7) begin
            pd_s = 1'b1;
        end
        nk++;
    end

    // ======================================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdq = prdata;
        rde = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16)
            miscompares++;
        if (w && rde === 1'b0 && a == odt_pkg::CFG_OFS)
            cfg_s = d;
    endtask

    // Writes the configuration word and expects no slave error.
    task automatic setcfg(input logic [31:0] v);
        apb(1'b1, odt_pkg::CFG_OFS, v);
        check(rde, 1'b0);
    endtask

    task automatic run(input logic c, input logic o, input logic [3:0] m,
                       input logic b);
        int j, lat;
        logic on, ws;
        ddr_ctrl_model_inst.step(c, o, m, b);
        j = nk - 1;
        lat = cfg_s[15:12] + cfg_s[20:16] - 2;
        on = j >= lat && odt_h[(j - lat) % 64] &&
             (cfg_s[3:1] != 3'h0 || cfg_s[6:5] != 2'h0);
        on = on && !sref_s;
        ws = 1'b0;
        for (int i = 0; i < 6; i++)
            if (j - lat - i >= 0 && wr_h[(j - lat - i) % 64] > i)
                ws = cfg_s[6:5] != 2'h0;
        check(term_dq_on, on);
        check(term_tdqs_on, on && cfg_s[4]);
        check(term_wr_sel, ws);
        check(term_strength,
              ws ? {1'b0, cfg_s[6:5]} : cfg_s[3:1]);
        check(in_power_down, pd_s);
        check(in_self_refresh, sref_s);
    endtask

    // ODT stays high at least four edges and past each write's own minimum, so the
    // later of both holds is kept.
    task automatic burst(input int hold, input int wat, input logic b);
        for (int i = 0; i < hold; i++)
            run(1'b1, 1'b1, (i == wat) ? WR : NOP, b);
        repeat (14) run(1'b1, 1'b0, NOP, 1'b0);
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, pclk, pd_s, sref_s} = 7'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        cfg_s = 32'h0000_5000;
        {nk, miscompares, num_checks} = {32'd0, 32'd0, 32'd0};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, odt_pkg::CFG_OFS, 32'h0);
        check(rdq, 32'h0000_5000);
        apb(1'b1, odt_pkg::STAT_OFS, 32'hffff_ffff);
        check(rde, 1'b0);
        apb(1'b0, odt_pkg::CFG_OFS, 32'h0);
        check(rdq, 32'h0000_5000);
        apb(1'b0, 8'h08, 32'h0);
        check(rde, 1'b1);
        check(rdq, 32'h0000_0000);
        apb(1'b0, odt_pkg::STAT_OFS, 32'h0);
        check({rdq[13:8], rdq[5], rdq[0]}, 8'h0c);
        burst(4, -1, 1'b0);
        foreach (enb[k]) begin
            setcfg(32'h5000 | (32'h1 << enb[k]));
            burst(5, -1, 1'b0);
        end
        foreach (dcfg[k]) begin
            setcfg(dcfg[k]);
            burst(dhold[k], dwat[k], db[k]);
        end
        apb(1'b0, odt_pkg::STAT_OFS, 32'h0);
        check(rdq[13:8], 6'h08);
        setcfg(32'h0000_5107);
        burst(5, 1, 1'b0);
        // ODT is low around the read.
        repeat (2) run(1'b1, 1'b0, RD, 1'b0);
        run(1'b0, 1'b0, NOP, 1'b0);
        for (int i = 0; i < 4; i++)
            run(1'b0, 1'b1, (i == 0) ? WR : NOP, 1'b0);
        repeat (9) run(1'b0, 1'b0, NOP, 1'b0);
        // Power-down with the DLL kept keeps synchronous timing.
        apb(1'b0, odt_pkg::STAT_OFS, 32'h0);
        check(rdq[4:2], 3'h5);
        setcfg(32'h0000_5106);
        apb(1'b0, odt_pkg::STAT_OFS, 32'h0);
        check(rdq[4:2], 3'h1);
        setcfg(32'h0000_5107);
        // CKE stays high with no command until exit delays pass.
        run(1'b1, 1'b0, DES, 1'b0);
        repeat (ddr_ctrl_model_inst.EXIT_WAIT) run(1'b1, 1'b0, NOP, 1'b0);
        run(1'b0, 1'b0, REF, 1'b0);
        repeat (4) run(1'b0, 1'b1, NOP, 1'b0);
        repeat (2) run(1'b0, 1'b0, NOP, 1'b0);
        run(1'b1, 1'b0, NOP, 1'b0);
        repeat (12) run(1'b1, 1'b0, NOP, 1'b0);
        tally_and_finish();
    end

    initial begin
        #1000000;
        miscompares++;
        tally_and_finish();
    end
endmodule
